// ---- hw/lcd_command_decoder.sv ----
// Command decoder of a dot-matrix LCD driver, reached over APB.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
module lcd_command_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] scan_page,
  input wire logic [7:0] scan_segment,
  output logic [7:0] segment_output,
  output logic segment_reverse,
  output logic display_reverse,
  output logic all_points_on,
  output logic bias_select,
  output logic display_off,
  output logic power_save
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic op_match(input logic [7:0] value, input logic [7:0] op,
                                    input logic [7:0] mask);
    op_match = ((value & mask) == op);
  endfunction

  function automatic logic [10:0] ram_index(input logic [3:0] page, input logic [7:0] col);
    ram_index = 11'(page) * 11'(lcd_pkg::COLS) + 11'(col);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [3:0] page;
  logic [7:0] column;
  logic [7:0] saved_column;
  logic rmw_mode;
  logic serial_mode;
  logic [7:0] read_latch;
  logic busy;
  logic [7:0] ram_rd_data;
  logic [7:0] scan_data;

  // ****************************************
  // APB decode
  // ****************************************
  wire [3:0] addr_low = paddr[3:0];
  wire in_range = (paddr[31:4] == 28'h000_0000);
  wire hit_cmd = in_range & (addr_low == lcd_pkg::ADDR_CMD);
  wire hit_data = in_range & (addr_low == lcd_pkg::ADDR_DATA);
  wire hit_cursor = in_range & (addr_low == lcd_pkg::ADDR_CURSOR);
  wire hit_state = in_range & (addr_low == lcd_pkg::ADDR_STATE);
  wire mapped = hit_cmd | hit_data | hit_cursor | (hit_state & ~pwrite);
  wire access = psel & penable & ~pready;
  wire done = psel & penable & pready;
  // Commands and data wait out the busy time; status stays readable
  wire stall = busy & (hit_data | (hit_cmd & pwrite));
  wire [7:0] wbyte = pwdata[7:0];

  // Qualified transfers at the completing edge
  wire cmd_wr = done & hit_cmd & pwrite;
  wire data_wr = done & hit_data & pwrite;
  wire data_rd_ok = hit_data & ~pwrite & ~serial_mode;
  wire data_rd = done & data_rd_ok;
  wire cursor_wr = done & hit_cursor & pwrite;

  // Command decode; bit 0 ignored for paired commands, full byte compared for the rest
  wire c_display = cmd_wr & op_match(wbyte, lcd_pkg::OP_DISPLAY, lcd_pkg::PAIR_MASK);
  wire c_seg = cmd_wr & op_match(wbyte, lcd_pkg::OP_SEG_DIR, lcd_pkg::PAIR_MASK);
  wire c_bias = cmd_wr & op_match(wbyte, lcd_pkg::OP_BIAS, lcd_pkg::PAIR_MASK);
  wire c_all = cmd_wr & op_match(wbyte, lcd_pkg::OP_ALL_ON, lcd_pkg::PAIR_MASK);
  wire c_rev = cmd_wr & op_match(wbyte, lcd_pkg::OP_REVERSE, lcd_pkg::PAIR_MASK);
  wire c_rmw = cmd_wr & op_match(wbyte, lcd_pkg::OP_RMW, lcd_pkg::FULL_MASK);
  wire c_reset = cmd_wr & op_match(wbyte, lcd_pkg::OP_RESET, lcd_pkg::FULL_MASK);
  wire c_end = cmd_wr & op_match(wbyte, lcd_pkg::OP_END, lcd_pkg::FULL_MASK);

  // ****************************************
  // Column pointer
  // ****************************************
  // Increment counts in RAM order and saturates at the last column
  wire [7:0] col_inc = (column >= lcd_pkg::LAST_COL) ? column :
                       column + lcd_pkg::COL_ONE;
  // Reads hold the column in read/modify/write mode, writes always advance
  wire advance = data_wr | (data_rd & ~rmw_mode);
  wire [7:0] next_column = c_reset ? 8'h00 :
                           (c_end & rmw_mode) ? saved_column :
                           cursor_wr ? pwdata[lcd_pkg::CUR_COL_LSB +: 8] :
                           advance ? col_inc : column;
  wire [3:0] next_page = c_reset ? 4'h0 :
                         cursor_wr ? pwdata[lcd_pkg::CUR_PAGE_LSB +: 4] : page;
  wire [10:0] host_index = ram_index(page, column);

  // Pointer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column <= 8'h00;
      page <= 4'h0;
    end else begin
      column <= next_column;
      page <= next_page;
    end
  end

  // Read/modify/write mode and the column it returns to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rmw_mode <= 1'b0;
      saved_column <= 8'h00;
    end else if (c_rmw) begin
      rmw_mode <= 1'b1;
      saved_column <= column;
    end else if (c_end | c_reset) begin
      rmw_mode <= 1'b0;
    end
  end

  // Output latch: a read hands over the old byte and refills from the column it
  // just addressed, before the pointer moves; so the first read after moving the
  // column is a dummy, and later reads return successive columns, or the same column in read/modify/write mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_latch <= 8'h00;
    end else if (data_rd) begin
      read_latch <= ram_rd_data;
    end
  end

  // ****************************************
  // Display settings
  // ****************************************
  // Hardware reset only; the reset command leaves these settings alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_reverse <= 1'b0;
      display_reverse <= 1'b0;
      all_points_on <= 1'b0;
      bias_select <= 1'b0;
      display_off <= 1'b1;
      serial_mode <= 1'b0;
    end else begin
      if (c_seg) segment_reverse <= wbyte[0];
      if (c_rev) display_reverse <= wbyte[0];
      if (c_all) all_points_on <= wbyte[0];
      if (c_bias) bias_select <= wbyte[0];
      if (c_display) display_off <= ~wbyte[0];
      if (cursor_wr) serial_mode <= pwdata[lcd_pkg::CUR_SERIAL_BIT];
    end
  end

  // Power save follows the two settings one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save <= 1'b0;
    end else begin
      power_save <= all_points_on & display_off;
    end
  end

  // ****************************************
  // Segment scan path
  // ****************************************
  // Reversed order drives segment n from column 131-n
  wire [7:0] scan_col = segment_reverse ? (lcd_pkg::LAST_COL - scan_segment) :
                        scan_segment;
  // All-on wins over polarity; RAM is never rewritten by either
  wire [7:0] next_segment = all_points_on ? 8'hff :
                            (display_reverse ? ~scan_data : scan_data);

  // Registered pixel byte for the selected segment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_output <= 8'h00;
    end else begin
      segment_output <= next_segment;
    end
  end

  // ****************************************
  // Status and read mux
  // ****************************************
  wire [7:0] status = {busy, ~segment_reverse, display_off, busy, 4'h0};
  wire [31:0] cursor_rd = {15'h0000, serial_mode, column, 4'h0, page};
  wire [31:0] state_rd = {25'h000_0000, rmw_mode, power_save, display_off,
                          bias_select, all_points_on, display_reverse, segment_reverse};
  wire [31:0] next_prdata = (pwrite | ~mapped) ? 32'h0000_0000 :
                            hit_cmd ? {24'h00_0000, status} :
                            data_rd_ok ? {24'h00_0000, read_latch} :
                            hit_cursor ? cursor_rd :
                            hit_state ? state_rd : 32'h0000_0000;
  // Unmapped, state writes and serial-mode data reads are errors
  wire next_err = ~mapped | (hit_data & ~pwrite & serial_mode);

  // One wait state; a stalled access holds pready low until init ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~stall;
      pslverr <= access & ~stall & next_err;
      prdata <= (access & ~stall) ? next_prdata : 32'h0000_0000;
    end
  end

  // ****************************************
  // Sub-blocks
  // ****************************************
  lcd_init_timer init_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(c_reset),
    .busy(busy)
  );

  lcd_display_ram display_ram (
    .pclk(pclk),
    .wr_en(data_wr),
    .wr_index(host_index),
    .wr_data(wbyte),
    .rd_index(host_index),
    .rd_data(ram_rd_data),
    .scan_index(ram_index(scan_page, scan_col)),
    .scan_data(scan_data)
  );
endmodule

// ---- hw/lcd_display_ram.sv ----
// Display data RAM in flip-flops, one host port and one scan read port.
`timescale 1ns/100ps
module lcd_display_ram (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [10:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [10:0] rd_index,
  output logic [7:0] rd_data,
  input wire logic [10:0] scan_index,
  output logic [7:0] scan_data
);
  logic [7:0] mem [lcd_pkg::RAM_DEPTH];

  // No reset: display contents survive both reset kinds
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
  end

  // Out-of-range index reads zero rather than an undefined entry
  assign rd_data = (rd_index < 11'(lcd_pkg::RAM_DEPTH)) ? mem[rd_index] : 8'h00;
  assign scan_data = (scan_index < 11'(lcd_pkg::RAM_DEPTH)) ? mem[scan_index] : 8'h00;
endmodule

// ---- hw/lcd_init_timer.sv ----
// Initialisation timer: holds the busy/reset-in-progress level for a fixed time.
`timescale 1ns/100ps
module lcd_init_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy
);
  logic [7:0] count;

  // Loaded at hardware reset so the first init runs without a command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'(lcd_pkg::INIT_CYCLES);
    end else if (start) begin
      count <= 8'(lcd_pkg::INIT_CYCLES);
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // Busy is a flop so readers see a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b1;
    end else begin
      busy <= start | (count > 8'h01);
    end
  end
endmodule

// ---- include/lcd_pkg.sv ----
// Shared constants for the LCD command decoder: offsets, opcodes, sizes and timing.
package lcd_pkg;
  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CMD = 4'h0;    // Command write / status read
  localparam logic [3:0] ADDR_DATA = 4'h4;   // Display data write / read
  localparam logic [3:0] ADDR_CURSOR = 4'h8; // Page and column pointer, serial select
  localparam logic [3:0] ADDR_STATE = 4'hc;  // Read-only display state

  // Cursor register fields
  localparam int CUR_PAGE_LSB = 0;
  localparam int CUR_COL_LSB = 8;
  localparam int CUR_SERIAL_BIT = 16;

  // State register fields
  localparam int ST_SEG_REV = 0;
  localparam int ST_DISP_REV = 1;
  localparam int ST_ALL_ON = 2;
  localparam int ST_BIAS = 3;
  localparam int ST_DISP_OFF = 4;
  localparam int ST_PSAVE = 5;
  localparam int ST_RMW = 6;

  // ****************************************
  // Command opcodes (bit 0 masked for paired commands)
  // ****************************************
  localparam logic [7:0] OP_DISPLAY = 8'h0_0ae;
  localparam logic [7:0] OP_SEG_DIR = 8'h0_0a0;
  localparam logic [7:0] OP_BIAS = 8'h0_0a2;
  localparam logic [7:0] OP_ALL_ON = 8'h0_0a4;
  localparam logic [7:0] OP_REVERSE = 8'h0_0a6;
  localparam logic [7:0] OP_RMW = 8'h0_0e0;
  localparam logic [7:0] OP_RESET = 8'h0_0e2;
  localparam logic [7:0] OP_END = 8'h0_0ee;
  localparam logic [7:0] PAIR_MASK = 8'h0_0fe;
  localparam logic [7:0] FULL_MASK = 8'h0_0ff;

  // ****************************************
  // Display RAM geometry
  // ****************************************
  localparam int PAGES = 9;
  localparam int COLS = 132;
  localparam int RAM_DEPTH = PAGES * COLS;
  localparam logic [7:0] LAST_COL = 8'h0_083;
  localparam logic [7:0] COL_ONE = 8'h0_001;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- sim/host_bus_model.sv ----
// Host processor model issuing APB transfers to the decoder.
`timescale 1ns/100ps
module host_bus_model (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata
);
  // ****************************************
  // Bus cycle
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
  end

  // Called just after a rising edge; request holds until ready is seen
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Released lines must not look valid
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// ---- sim/lcd_command_decoder_assertions.sv ----
// Checker for the LCD command decoder ports.
`timescale 1ns/100ps
module lcd_command_decoder_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] segment_output,
  input wire logic segment_reverse,
  input wire logic display_reverse,
  input wire logic all_points_on,
  input wire logic bias_select,
  input wire logic display_off,
  input wire logic power_save
);
  // ****************************************
  // Completed command writes and status reads
  // ****************************************
  wire logic ok = pready && psel && penable && !pslverr;
  wire logic at_cmd = paddr == 32'(lcd_pkg::ADDR_CMD);
  wire logic cmd_wr = ok && pwrite && at_cmd;
  wire logic stat_rd = ok && !pwrite && at_cmd;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_error_qualified: assert property (pslverr |-> pready) else $error("stray error");
  a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("data not idle");
  a_status_format: assert property (stat_rd |-> prdata[3:0] == 4'h0 &&
    prdata[7] == prdata[4] && prdata[31:8] == 24'h0) else $error("status format");
  a_status_seg: assert property (stat_rd |-> prdata[6] == !segment_reverse)
    else $error("status direction");
  a_status_off: assert property (stat_rd |-> prdata[5] == display_off)
    else $error("status display off");
  a_seg_cmd: assert property (cmd_wr && pwdata[7:0] == 8'ha1 |=> segment_reverse)
    else $error("direction command");
  a_rev_cmd: assert property (cmd_wr && pwdata[7:0] == 8'ha7 |=> display_reverse)
    else $error("reverse command");
  a_bias_cmd: assert property (cmd_wr && pwdata[7:0] == 8'ha2 |=> !bias_select)
    else $error("bias command");
  a_all_lit: assert property (all_points_on |=> segment_output == 8'hff)
    else $error("all points not lit");
  a_save_enter: assert property (all_points_on && display_off |=> power_save)
    else $error("no power save");
  a_save_exit: assert property (!display_off |=> !power_save)
    else $error("power save while on");
  c_rmw: cover property (cmd_wr && pwdata[7:0] == 8'he0);
  c_error: cover property (pslverr);
  c_busy: cover property (stat_rd && prdata[7]);
endmodule

// ---- sim/test_lcd_command_decoder.sv ----
// Self-checking bench for the LCD command decoder.
`timescale 1ns/100ps
module test_lcd_command_decoder;
  localparam logic [31:0] A_CMD = 32'(lcd_pkg::ADDR_CMD);
  localparam logic [31:0] A_DAT = 32'(lcd_pkg::ADDR_DATA);
  localparam logic [31:0] A_CUR = 32'(lcd_pkg::ADDR_CURSOR);
  localparam logic [31:0] A_ST = 32'(lcd_pkg::ADDR_STATE);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] scan_page;
  logic [7:0] scan_segment, segment_output, c;
  logic segment_reverse, display_reverse, all_points_on, bias_select, display_off, power_save;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [7:0] b[4];
  logic [6:0] st;
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h0000_4dbb;
  int i;
  logic scan_fix = 1'b0;
  logic [3:0] fix_page;
  logic [7:0] fix_seg;
  int pos[5] = '{0, 1, 3, 2, 4};
  logic [7:0] cmds[5] = '{8'ha1, 8'ha7, 8'ha3, 8'ha5, 8'hae};

  lcd_command_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scan_page(scan_page), .scan_segment(scan_segment),
    .segment_output(segment_output), .segment_reverse(segment_reverse),
    .display_reverse(display_reverse), .all_points_on(all_points_on),
    .bias_select(bias_select), .display_off(display_off), .power_save(power_save));
  host_bus_model host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ****************************************
  // Clock, scan stimulus, result monitor
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Random scan position keeps the view path busy, unless a check pins it
  always @(posedge pclk) begin
    scan_page <= scan_fix ? fix_page : 4'($random(seed) & 7);
    scan_segment <= scan_fix ? fix_seg : 8'($random(seed));
  end

  // Oldest note is {care, error, data}; an unexpected answer fails
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      note = (notes.size() > 0) ? notes.pop_front() : 34'h3_ffff_ffff;
      n_checks++;
      if (pslverr !== note[32] || (note[33] && prdata !== note[31:0])) begin
        err_total++;
        $display("CHECK FAILED at %0t: got %h/%b want %h", $time, prdata, pslverr, note[31:0]);
      end
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    notes.push_back({2'b00, 32'h0000_0000});
    host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic care);
    notes.push_back({care, 1'b0, e});
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Pins the scan position; the pixel byte settles one edge after it lands
  task automatic view(input logic [3:0] p, input logic [7:0] s, input logic [7:0] e);
    scan_fix <= 1'b1;
    fix_page <= p;
    fix_seg <= s;
    repeat (3) @(posedge pclk);
    n_checks++;
    if (segment_output !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: segment %h want %h", $time, segment_output, e);
    end
    scan_fix <= 1'b0;
  endtask

  task automatic bad(input logic w, input logic [31:0] a);
    notes.push_back({2'b11, 32'h0000_0000});
    host.xfer(w, a, 32'h0000_0000);
  endtask

  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the 62 transfers below
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CMD, 32'h0000_00f0, 1'b1);
    wr(A_CMD, 32'h0000_00af);
    rd(A_CMD, 32'h0000_0040, 1'b1);
    wr(A_CUR, 32'h0000_8102);
    for (i = 0; i < 4; i++) begin
      b[i] = 8'($random(seed));
      wr(A_DAT, {24'h0, b[i]});
    end
    rd(A_CUR, 32'h0000_8302, 1'b1);
    wr(A_CUR, 32'h0000_8102);
    rd(A_DAT, 32'h0, 1'b0);
    rd(A_DAT, {24'h0, b[0]}, 1'b1);
    rd(A_DAT, {24'h0, b[1]}, 1'b1);
    rd(A_DAT, {24'h0, b[3]}, 1'b1);
    wr(A_CMD, 32'h0000_00a1);
    wr(A_CUR, 32'h0000_1002);
    wr(A_DAT, 32'h0000_005a);
    rd(A_CUR, 32'h0000_1102, 1'b1);
    view(4'h2, 8'h73, 8'h5a);
    wr(A_CMD, 32'h0000_00a0);
    wr(A_CUR, 32'h0000_1002);
    wr(A_CMD, 32'h0000_00e0);
    rd(A_DAT, 32'h0, 1'b0);
    rd(A_DAT, 32'h0000_005a, 1'b1);
    rd(A_CUR, 32'h0000_1002, 1'b1);
    wr(A_DAT, 32'h0000_00a5);
    rd(A_CUR, 32'h0000_1102, 1'b1);
    wr(A_CMD, 32'h0000_00ee);
    rd(A_CUR, 32'h0000_1002, 1'b1);
    rd(A_ST, 32'h0, 1'b1);
    rd(A_DAT, 32'h0, 1'b0);
    rd(A_CUR, 32'h0000_1102, 1'b1);
    view(4'h2, 8'h81, b[0]);
    st = 7'h00;
    for (i = 0; i < 10; i++) begin
      c = cmds[i % 5] ^ 8'(i >= 5);
      st[pos[i % 5]] = (pos[i % 5] == 4) ? ~c[0] : c[0];
      st[5] = st[2] & st[4];
      wr(A_CMD, {24'h0, c});
      rd(A_ST, {25'h0, st}, 1'b1);
      if (i == 1) view(4'h2, 8'h02, ~b[0]);
    end
    wr(A_CMD, 32'h0000_01a8);
    rd(A_ST, 32'h0, 1'b1);
    wr(A_CUR, 32'h0001_0000);
    bad(1'b0, A_DAT);
    wr(A_DAT, 32'h0000_0033);
    bad(1'b0, 32'h0000_0010);
    bad(1'b1, A_ST);
    wr(A_CMD, 32'h0000_00e2);
    rd(A_CMD, 32'h0000_00d0, 1'b1);
    wr(A_CMD, 32'h0000_00a1);
    rd(A_CMD, 32'h0000_0000, 1'b1);
    end_of_test();
  end
endmodule

bind lcd_command_decoder lcd_command_decoder_assertions chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .segment_output(segment_output),
  .segment_reverse(segment_reverse), .display_reverse(display_reverse),
  .all_points_on(all_points_on), .bias_select(bias_select), .display_off(display_off),
  .power_save(power_save));
